// *** felc_pkg.sv ***
// Constants, types and code tables of the fast ethernet line coder
`default_nettype none
package felc_pkg;
    // ****************************************
    // Code-groups and symbol framing
    // ****************************************
    localparam int SYM_BITS = 5;
    localparam logic [2:0] SYM_LAST = 3'h4;
    localparam logic [4:0] CG_IDLE = 5'h1F;
    localparam logic [4:0] CG_J = 5'h18;
    localparam logic [4:0] CG_K = 5'h11;
    localparam logic [4:0] CG_T = 5'h0D;
    localparam logic [4:0] CG_R = 5'h07;
    localparam logic [3:0] NIB_PREAMBLE = 4'h5;
    localparam logic [3:0] NIB_ERROR = 4'hE;
    localparam logic [15:0][4:0] CG_DATA = {
        5'h1D, 5'h1C, 5'h1B, 5'h1A, 5'h17, 5'h16, 5'h13, 5'h12,
        5'h0F, 5'h0E, 5'h0B, 5'h0A, 5'h15, 5'h14, 5'h09, 5'h1E};
    // ****************************************
    // Scrambler
    // ****************************************
    localparam int LFSR_W = 11;
    localparam logic [10:0] LFSR_RESET = 11'h7FF;
    localparam logic [5:0] SEED_LOW = 6'h2B;
    // ****************************************
    // Signal detect qualification: gap in bit times, run in edges
    // ****************************************
    localparam logic [5:0] SD_GAP_BITS = 6'h20;
    localparam logic [5:0] SD_RUN_EDGES = 6'h10;
    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_SSD_K = 2'b01,
        TX_DATA = 2'b10,
        TX_ESD_R = 2'b11
    } felc_tx_state_t;
    typedef struct packed {
        logic en;
        logic [3:0] data;
    } felc_tx_mii_t;
    typedef struct packed {
        logic dv;
        logic er;
        logic [3:0] data;
    } felc_rx_mii_t;
endpackage
`default_nettype wire

// *** felc_line_coder.sv ***
// Fast ethernet line coder: 4B/5B, NRZI and MLT-3 both ways, scrambler on transmit only
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Each MAC nibble is sent as its 5-bit code-group.
// - First preamble byte is replaced by the J/K pair 11000 10001.
// - Remaining preamble and data nibbles are coded while the frame lasts.
// - When transmit enable drops, send T/R pair 01101 00111.
// - After T/R, idles are sent until transmit enable returns.
// - Idle, start or R groups inside received data flag a receive error; T ends the frame without one.
// - Scrambler is a closed-loop 11-bit LFSR.
// - Unless scr_bypass is set, every serial code bit is XORed with the LFSR output.
// - Scrambler seed is the five PHY address straps above the fixed low bits SEED_LOW.
// - Scrambled stream is NRZI encoded before the line stage.
// - NRZI stream splits into two drive streams with alternating one events.
// - Transmit output is MLT-3 only; no binary output mode exists.
// - Received MLT-3 stream is turned back into nibbles for the MAC.
// - Link pulses alone never raise signal detect.
// - Three-level receive symbols decode to NRZI ahead of NRZ decoding.
// - Between packets the idle group 11111 is sent.
// - A bypass input passes code-groups through unscrambled.
module felc_line_coder
    import felc_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [4:0] phy_address_straps,
    input wire logic scr_bypass,
    input wire felc_tx_mii_t tx_mii,
    output logic tx_nib_req_ff,
    output logic tx_drive_pos_ff,
    output logic tx_drive_neg_ff,
    input wire logic rx_lvl_pos,
    input wire logic rx_lvl_neg,
    output logic sig_detect_ff,
    output felc_rx_mii_t rx_mii_ff,
    output logic rx_nib_strobe_ff
);
    // ****************************************
    // Transmit code-group selection
    // ****************************************
    felc_tx_state_t tx_st_ff, nxt_tx_st;
    logic [2:0] tx_cnt_ff;
    logic [SYM_BITS-1:0] tx_sr_ff;
    logic [4:0] nxt_grp;
    wire tx_load = (tx_cnt_ff == SYM_LAST);
    wire [4:0] data_grp = CG_DATA[tx_mii.data];

    always_comb begin
        nxt_tx_st = tx_st_ff;
        nxt_grp = CG_IDLE;
        unique case (tx_st_ff)
            TX_IDLE: begin
                if (tx_mii.en) begin
                    nxt_grp = CG_J;
                    nxt_tx_st = TX_SSD_K;
                end
            end
            TX_SSD_K: begin
                nxt_grp = CG_K;
                nxt_tx_st = TX_DATA;
            end
            TX_DATA: begin
                if (tx_mii.en) begin
                    nxt_grp = data_grp;
                end else begin
                    nxt_grp = CG_T;
                    nxt_tx_st = TX_ESD_R;
                end
            end
            TX_ESD_R: begin
                nxt_grp = CG_R;
                nxt_tx_st = TX_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            tx_st_ff <= TX_IDLE;
            tx_cnt_ff <= 3'h0;
            tx_sr_ff <= CG_IDLE;
            tx_nib_req_ff <= 1'b0;
        end else begin
            tx_cnt_ff <= tx_load ? 3'h0 : tx_cnt_ff + 3'h1;
            tx_nib_req_ff <= (tx_cnt_ff == SYM_LAST - 3'h1);
            if (tx_load) begin
                tx_st_ff <= nxt_tx_st;
                tx_sr_ff <= nxt_grp;
            end else begin
                tx_sr_ff <= {tx_sr_ff[3:0], 1'b0};
            end
        end
    end

    // ****************************************
    // Scrambler, NRZI and MLT-3 drive
    // ****************************************
    logic [LFSR_W-1:0] lfsr_ff;
    logic seed_pend_ff;
    logic nrzi_ff;
    logic [1:0] mlt_phase_ff;
    wire lfsr_fb = lfsr_ff[10] ^ lfsr_ff[8];
    wire scr_bit = scr_bypass ? tx_sr_ff[4] : tx_sr_ff[4] ^ lfsr_ff[10];
    wire nxt_nrzi = nrzi_ff ^ scr_bit;
    // The line steps only where the NRZI level changes
    wire nrzi_step = nxt_nrzi ^ nrzi_ff;
    wire [1:0] nxt_phase = mlt_phase_ff + {1'b0, nrzi_step};

    always_ff @(posedge clk) begin
        if (srst) begin
            lfsr_ff <= LFSR_RESET;
            seed_pend_ff <= 1'b1;
            nrzi_ff <= 1'b0;
            mlt_phase_ff <= 2'h0;
            tx_drive_pos_ff <= 1'b0;
            tx_drive_neg_ff <= 1'b0;
        end else begin
            seed_pend_ff <= 1'b0;
            if (seed_pend_ff) begin
                lfsr_ff <= {phy_address_straps, SEED_LOW};
            end else begin
                lfsr_ff <= {lfsr_ff[9:0], lfsr_fb};
            end
            nrzi_ff <= nxt_nrzi;
            mlt_phase_ff <= nxt_phase;
            tx_drive_pos_ff <= (nxt_phase == 2'h1);
            tx_drive_neg_ff <= (nxt_phase == 2'h3);
        end
    end

    // ****************************************
    // Receive line decode and signal detect
    // ****************************************
    logic [1:0] rx_lvl_ff;
    logic rx_nrzi_ff, rx_nrzi_prev_ff;
    logic [5:0] sd_gap_ff, sd_run_ff;
    wire [1:0] rx_lvl = {rx_lvl_pos, rx_lvl_neg};
    wire rx_edge = (rx_lvl != rx_lvl_ff);
    wire rx_nrz = rx_nrzi_ff ^ rx_nrzi_prev_ff;
    wire sd_gap_over = (sd_gap_ff >= SD_GAP_BITS);

    always_ff @(posedge clk) begin
        if (srst) begin
            rx_lvl_ff <= 2'h0;
            rx_nrzi_ff <= 1'b0;
            rx_nrzi_prev_ff <= 1'b0;
            sd_gap_ff <= 6'h0;
            sd_run_ff <= 6'h0;
            sig_detect_ff <= 1'b0;
        end else begin
            rx_lvl_ff <= rx_lvl;
            rx_nrzi_ff <= rx_nrzi_ff ^ rx_edge;
            rx_nrzi_prev_ff <= rx_nrzi_ff;
            if (rx_edge) begin
                sd_gap_ff <= 6'h0;
                sd_run_ff <= sd_gap_over ? 6'h1 : sd_run_ff + {5'h0, sd_run_ff != SD_RUN_EDGES};
            end else if (!sd_gap_over) begin
                sd_gap_ff <= sd_gap_ff + 6'h1;
            end
            // Isolated link pulses never build a dense enough edge run
            sig_detect_ff <= !sd_gap_over && (sd_run_ff == SD_RUN_EDGES);
        end
    end

    // ****************************************
    // Receive alignment and 5B/4B decode
    // ****************************************
    logic [9:0] rx_sr_ff;
    logic in_frame_ff, jk_pend_ff;
    logic [2:0] rx_cnt_ff;
    logic dec_ok;
    logic [3:0] dec_nib;
    wire [9:0] nxt_rx_sr = {rx_sr_ff[8:0], rx_nrz};
    wire [4:0] rx_grp = nxt_rx_sr[4:0];
    wire jk_seen = !in_frame_ff && sig_detect_ff && (nxt_rx_sr == {CG_J, CG_K});
    wire grp_tick = in_frame_ff && (rx_cnt_ff == SYM_LAST);
    wire grp_end = (rx_grp == CG_T) || (rx_grp == CG_IDLE);

    always_comb begin
        dec_ok = 1'b0;
        dec_nib = 4'h0;
        for (int i = 0; i < 16; i++) begin
            if (CG_DATA[i] == rx_grp) begin
                dec_ok = 1'b1;
                dec_nib = 4'(i);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rx_sr_ff <= 10'h0;
            in_frame_ff <= 1'b0;
            jk_pend_ff <= 1'b0;
            rx_cnt_ff <= 3'h0;
            rx_mii_ff <= '0;
            rx_nib_strobe_ff <= 1'b0;
        end else begin
            rx_sr_ff <= nxt_rx_sr;
            jk_pend_ff <= jk_seen;
            rx_nib_strobe_ff <= jk_seen || jk_pend_ff || (grp_tick && (rx_grp != CG_T));
            rx_cnt_ff <= (jk_seen || rx_cnt_ff == SYM_LAST) ? 3'h0 : rx_cnt_ff + 3'h1;
            if (jk_seen) begin
                in_frame_ff <= 1'b1;
                rx_mii_ff <= '{dv: 1'b1, er: 1'b0, data: NIB_PREAMBLE};
            end else if (grp_tick) begin
                in_frame_ff <= !grp_end;
                if (dec_ok) begin
                    rx_mii_ff <= '{dv: 1'b1, er: 1'b0, data: dec_nib};
                end else if (rx_grp == CG_T) begin
                    rx_mii_ff <= '0;
                end else begin
                    rx_mii_ff <= '{dv: 1'b1, er: 1'b1, data: NIB_ERROR};
                end
            end else if (!in_frame_ff && !jk_pend_ff) begin
                rx_mii_ff <= '0;
            end
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    property p_ssd_j;
        @(posedge clk) disable iff (srst) tx_load && tx_st_ff == TX_IDLE && tx_mii.en |=> tx_sr_ff == CG_J;
    endproperty
    a_ssd_j: assert property (p_ssd_j) else $error("J not sent at frame start");
    property p_ssd_k;
        @(posedge clk) disable iff (srst) tx_load && tx_st_ff == TX_IDLE && tx_mii.en |=> ##5 tx_sr_ff == CG_K;
    endproperty
    a_ssd_k: assert property (p_ssd_k) else $error("K does not follow J");
    property p_esd;
        @(posedge clk) disable iff (srst)
            tx_load && tx_st_ff == TX_DATA && !tx_mii.en |=> tx_sr_ff == CG_T ##5 tx_sr_ff == CG_R;
    endproperty
    a_esd: assert property (p_esd) else $error("T/R pair missing at frame end");
    property p_idle;
        @(posedge clk) disable iff (srst) tx_load && tx_st_ff == TX_IDLE && !tx_mii.en |=> tx_sr_ff == CG_IDLE;
    endproperty
    a_idle: assert property (p_idle) else $error("idle group not sent between frames");
    property p_data;
        @(posedge clk) disable iff (srst) tx_load && tx_st_ff == TX_DATA && tx_mii.en |=> tx_sr_ff == $past(data_grp);
    endproperty
    a_data: assert property (p_data) else $error("data nibble coded wrongly");
    property p_lfsr;
        @(posedge clk) disable iff (srst)
            !seed_pend_ff |=> lfsr_ff == {$past(lfsr_ff[9:0]), $past(lfsr_ff[10]) ^ $past(lfsr_ff[8])};
    endproperty
    a_lfsr: assert property (p_lfsr) else $error("scrambler step wrong");
    property p_mlt_hold;
        @(posedge clk) disable iff (srst) !scr_bit ##1 !scr_bit |=> $stable({tx_drive_pos_ff, tx_drive_neg_ff});
    endproperty
    a_mlt_hold: assert property (p_mlt_hold) else $error("line level moved without a one");
    property p_mlt_split;
        @(posedge clk) disable iff (srst) !(tx_drive_pos_ff && tx_drive_neg_ff);
    endproperty
    a_mlt_split: assert property (p_mlt_split) else $error("both drive streams active");
    property p_rx_ctrl_err;
        @(posedge clk) disable iff (srst) grp_tick && (rx_grp == CG_IDLE || rx_grp == CG_J) |=> rx_mii_ff.er;
    endproperty
    a_rx_ctrl_err: assert property (p_rx_ctrl_err) else $error("control group in data not flagged");
    property p_sd_gap;
        @(posedge clk) disable iff (srst) sd_gap_over |=> !sig_detect_ff;
    endproperty
    a_sd_gap: assert property (p_sd_gap) else $error("signal detect held across a line gap");
endmodule // felc_line_coder
`default_nettype wire

// *** felc_mac_model.sv ***
// Behavioural MAC that sends one frame over the transmit nibble interface
`timescale 1ns/1ps
`default_nettype none
module felc_mac_model
    import felc_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic req,
    input wire logic go,
    output var felc_tx_mii_t tx_mii
);
    int idx = 0;
    logic busy = 1'b0;
    initial tx_mii = '0;
    // Four preamble nibbles, then nibbles 0 to F; the nibble is held until the next request
    always @(posedge clk) begin
        if (srst) begin
            busy = 1'b0;
        end else if (req && busy) begin
            idx = idx + 1;
            busy = (idx < 20);
        end else if (req && go) begin
            busy = 1'b1;
            idx = 0;
        end
        #1;
        tx_mii.en <= busy;
        tx_mii.data <= (idx < 4) ? NIB_PREAMBLE : 4'(idx - 4);
    end
endmodule // felc_mac_model
`default_nettype wire

// *** tb_fast_ethernet_pcs_line_coder.sv ***
// Self-checking bench for the fast ethernet line coder
`timescale 1ns/1ps
`default_nettype none
module tb_fast_ethernet_pcs_line_coder
    import felc_pkg::*;
;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [4:0] straps = 5'h0A;
    logic bypass = 1'b1;
    logic go = 1'b0;
    logic rpos = 1'b0;
    logic rneg = 1'b0;
    logic req, dpos, dneg, sd, strobe;
    felc_tx_mii_t tx_mii;
    felc_rx_mii_t rx_mii;
    felc_rx_mii_t rxq[$];
    logic [1:0] last_lvl = 2'b00;
    logic [1:0] last_nz = 2'b01;
    int mst = 0;
    int err_count = 0;
    int num_checks = 0;
    always #10 clk = ~clk;
    felc_mac_model mac (.clk(clk), .srst(srst), .req(req), .go(go), .tx_mii(tx_mii));
    felc_line_coder dut (.clk(clk), .srst(srst), .phy_address_straps(straps), .scr_bypass(bypass),
        .tx_mii(tx_mii), .tx_nib_req_ff(req), .tx_drive_pos_ff(dpos), .tx_drive_neg_ff(dneg),
        .rx_lvl_pos(rpos), .rx_lvl_neg(rneg), .sig_detect_ff(sd), .rx_mii_ff(rx_mii),
        .rx_nib_strobe_ff(strobe));
    always @(posedge clk) if (strobe) rxq.push_back(rx_mii);
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic wrap_up();
        if (err_count == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic do_reset(input logic [4:0] s, input logic byp);
        @(posedge clk);
        #1;
        srst = 1'b1;
        straps = s;
        bypass = byp;
        repeat (5) @(posedge clk);
        #1;
        srst = 1'b0;
        last_lvl = 2'b00;
        last_nz = 2'b01;
    endtask
    // One line bit per cycle: a level change is a one; nonzero levels must alternate
    task automatic get_bit(output logic b);
        @(posedge clk);
        #2;
        b = ({dpos, dneg} != last_lvl);
        if (b && (dpos || dneg)) begin
            check({dpos, dneg}, (last_nz == 2'b01) ? 2'b10 : 2'b01, "line phase");
            last_nz = {dpos, dneg};
        end
        last_lvl = {dpos, dneg};
    endtask
    task automatic rx_group(input logic [4:0] g);
        for (int i = 4; i >= 0; i--) begin
            @(posedge clk);
            #1;
            if (g[i]) mst = (mst + 1) % 4;
            rpos = (mst == 1);
            rneg = (mst == 3);
        end
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_seed(input logic [4:0] s, output logic [59:0] seq);
        logic b;
        do_reset(s, 1'b0);
        repeat (20) get_bit(b);
        for (int i = 0; i < 60; i++) begin
            get_bit(b);
            seq[i] = b;
        end
        for (int i = 0; i < 49; i++) check(seq[i+11], seq[i] ^ seq[i+2] ^ 1'b1, "scrambled idle");
    endtask
    task automatic t_tx();
        logic b;
        logic [9:0] sh;
        logic [4:0] g;
        int n;
        int nreq;
        logic [4:0] exp_g;
        sh = '0;
        n = 0;
        nreq = 0;
        do_reset(5'h03, 1'b1);
        repeat (10) get_bit(b);
        for (int i = 0; i < 20; i++) begin
            get_bit(b);
            if (req === 1'b1) nreq++;
            check(b, 1'b1, "bypassed idle bit");
        end
        check(nreq, 4, "nibble request pace");
        go = 1'b1;
        while (sh != {CG_J, CG_K} && n < 300) begin
            get_bit(b);
            sh = {sh[8:0], b};
            n++;
        end
        go = 1'b0;
        check(sh, {CG_J, CG_K}, "start pair");
        for (int k = 0; k < 23; k++) begin
            for (int i = 0; i < 5; i++) begin
                get_bit(b);
                g = {g[3:0], b};
            end
            exp_g = (k < 2) ? CG_DATA[5] : (k < 18) ? CG_DATA[k-2] : (k == 18) ? CG_T : (k == 19) ? CG_R : CG_IDLE;
            check(g, exp_g, "code group");
        end
    endtask
    task automatic t_rx();
        logic [0:8][5:0] ex;
        ex = {6'h25, 6'h25, 6'h23, 6'h2C, 6'h25, 6'h25, 6'h29, 6'h3E, 6'h3E};
        rxq.delete();
        repeat (6) rx_group(CG_IDLE);
        check(sd, 1'b1, "signal detect on idles");
        rx_group(CG_J);
        rx_group(CG_K);
        rx_group(CG_DATA[3]);
        rx_group(CG_DATA[12]);
        rx_group(CG_T);
        rx_group(CG_R);
        repeat (3) rx_group(CG_IDLE);
        rx_group(CG_J);
        rx_group(CG_K);
        rx_group(CG_DATA[9]);
        rx_group(CG_J);
        repeat (4) rx_group(CG_IDLE);
        check(rxq.size(), 9, "nibble count");
        for (int i = 0; i < 9 && i < rxq.size(); i++) check(rxq[i], ex[i], "rx nibble");
    endtask
    task automatic t_pulse();
        logic seen;
        seen = 1'b0;
        for (int c = 0; c < 2040; c++) begin
            @(posedge clk);
            #1;
            rpos = (c >= 40) && ((c - 40) % 200 < 12);
            rneg = 1'b0;
            if (c >= 38) seen = seen | sd;
        end
        check(seen, 1'b0, "signal detect on link pulses");
    endtask
    initial begin
        logic [59:0] s1, s2;
        t_seed(5'h0A, s1);
        t_seed(5'h15, s2);
        check(s1 != s2, 1'b1, "seed per strap value");
        t_tx();
        t_rx();
        t_pulse();
        wrap_up();
    end
    initial begin
        #200000;
        err_count++;
        wrap_up();
    end
endmodule // tb_fast_ethernet_pcs_line_coder
`default_nettype wire
